/* File: common/eeprom_map.svh */
// Purpose: constants of the two-wire serial memory link
// Assumes: controller clock 40 MHz, device sampling clock period 6 ns
// Notes:   timing counts derive from times kept in their own units
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ****************************************
// storage layout
// ****************************************
`define MEM_BYTES       256
`define PAGE_BYTES      8
`define DEV_TYPE        4'ha

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS   25
`define LINK_PERIOD_NS  6
`define SCL_PERIOD_NS   2500
`define NOISE_NS        50
`define PROG_TIME_US    3000
`define QUARTER_CYCLES  ((`SCL_PERIOD_NS / 4) / `CLK_PERIOD_NS)
`define FILT_CYCLES     (`NOISE_NS / `LINK_PERIOD_NS)
`define PROG_CYCLES     ((`PROG_TIME_US * 1000) / `LINK_PERIOD_NS)

`endif

/* File: common/eeprom_pkg.sv */
// Purpose: shared types of the serial memory link
// Assumes: nothing beyond the map header
// Notes:   state codes are one-hot
package eeprom_pkg;

	// ****************************************
	// controller command and state
	// ****************************************
	typedef enum logic [2:0] {
		OP_START   = 3'h0,
		OP_STOP    = 3'h1,
		OP_WRITE   = 3'h2,
		OP_READ    = 3'h3,
		OP_RECOVER = 3'h4
	} op_e;

	typedef enum logic [4:0] {
		C_IDLE  = 5'h01,
		C_START = 5'h02,
		C_STOP  = 5'h04,
		C_XFER  = 5'h08,
		C_RECOV = 5'h10
	} ctrl_state_e;

	// ****************************************
	// device state
	// ****************************************
	typedef enum logic [5:0] {
		D_STANDBY  = 6'h01,
		D_DEVADDR  = 6'h02,
		D_WORDADDR = 6'h04,
		D_WDATA    = 6'h08,
		D_RDATA    = 6'h10,
		D_PROG     = 6'h20
	} dev_state_e;

endpackage : eeprom_pkg

/* File: common/twi_if.sv */
// Purpose: two-wire link between bus controller and memory device
// Assumes: both data drivers are open-drain, clock driven by controller only
// Notes:   the shared data line is resolved here with an implied pull-up
`timescale 1ns/1ps
interface twi_if;
	logic scl;
	logic ctrl_sda_o;
	logic ctrl_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// a driver only ever pulls low; released line floats high
	assign sda = ~((ctrl_sda_oe & ~ctrl_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport ctrl (output scl, output ctrl_sda_o, output ctrl_sda_oe, input sda);
	modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : twi_if

/* File: design/sync_filter.sv */
// Purpose: two-flop synchroniser followed by a glitch filter
// Assumes: raw input asynchronous to clk
// Notes:   output follows only after CYCLES stable samples
`timescale 1ns/1ps
module sync_filter #(
	parameter int CYCLES = 8
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// line
	input  wire logic raw,
	output logic      level
);
	localparam int CW = $clog2(CYCLES + 1);

	logic          meta_q;
	logic          sync_q;
	logic [CW-1:0] cnt_q;

	always_ff @(posedge clk) begin
		meta_q <= raw;
		sync_q <= meta_q;
	end

	// idle bus reads high, so that is the safe value after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			level <= 1'b1;
			cnt_q <= '0;
		end else if (sync_q == level) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(CYCLES - 1)) begin
			level <= sync_q;
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
endmodule : sync_filter

/* File: design/twi_ctrl.sv */
// Purpose: bus controller end, one start, stop, byte or recovery per command
// Assumes: commands on clock; serial clock made by a divider of clock
// Notes:   each bit is four quarter periods: low, data, high, sample
`timescale 1ns/1ps
`include "eeprom_map.svh"
module twi_ctrl #(
	parameter int QUARTER = `QUARTER_CYCLES
) (
	// clock and reset
	input  wire logic           clock,
	input  wire logic           sys_rst,
	// command
	input  wire logic           cmd_valid,
	output logic                cmd_ready,
	input  eeprom_pkg::op_e     cmd_op,
	input  wire logic [7:0]     cmd_data,
	input  wire logic           cmd_ack,
	// answer
	output logic                rsp_valid,
	output logic [7:0]          rsp_data,
	output logic                rsp_nack,
	// link
	twi_if.ctrl                 bus
);
	import eeprom_pkg::*;

	localparam int QW = $clog2(QUARTER + 1);

	ctrl_state_e   state_q;
	op_e           op_q;
	logic [QW-1:0] qcnt_q;
	logic [1:0]    ph_q;
	logic [3:0]    bit_q;
	logic [7:0]    sh_q;
	logic          ack_q;
	logic          scl_q;
	logic          low_q;
	logic          sda_m_q;
	logic          sda_s_q;
	logic          tick;

	function automatic ctrl_state_e op_state(input op_e op);
		case (op)
			OP_START:   return C_START;
			OP_STOP:    return C_STOP;
			OP_RECOVER: return C_RECOV;
			default:    return C_XFER;
		endcase
	endfunction : op_state

	// ****************************************
	// pins and divider
	// ****************************************
	assign bus.scl         = scl_q;
	assign bus.ctrl_sda_o  = 1'b0;
	assign bus.ctrl_sda_oe = low_q;
	assign cmd_ready       = (state_q == C_IDLE);
	assign tick            = (qcnt_q == QW'(QUARTER - 1));

	always_ff @(posedge clock) begin
		sda_m_q <= bus.sda;
		sda_s_q <= sda_m_q;
	end

	always_ff @(posedge clock) begin
		if (sys_rst || state_q == C_IDLE || tick) begin
			qcnt_q <= '0;
		end else begin
			qcnt_q <= qcnt_q + QW'(1);
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	// data moves one quarter after the clock falls, never with it
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q   <= C_IDLE;
			op_q      <= OP_START;
			ph_q      <= 2'h0;
			bit_q     <= 4'h0;
			sh_q      <= 8'h00;
			ack_q     <= 1'b0;
			scl_q     <= 1'b1;
			low_q     <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= 8'h00;
			rsp_nack  <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			if (state_q == C_IDLE) begin
				if (cmd_valid) begin
					state_q <= op_state(cmd_op);
					op_q    <= cmd_op;
					sh_q    <= cmd_data;
					ack_q   <= cmd_ack;
					ph_q    <= 2'h0;
					bit_q   <= 4'h0;
				end
			end else if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (ph_q)
					2'h0: scl_q <= 1'b0; // RULE4
					2'h1: begin
						case (state_q)
							C_STOP:  low_q <= 1'b1;
							C_XFER:  low_q <= (bit_q == 4'h8) ? (op_q == OP_READ && ack_q)
							                 : (op_q == OP_WRITE && !sh_q[7]);
							default: low_q <= 1'b0; // RULE9
						endcase
					end
					2'h2: scl_q <= 1'b1;
					default: begin
						case (state_q)
							C_START: begin
								low_q   <= 1'b1; // RULE5
								state_q <= C_IDLE;
							end
							C_STOP: begin
								low_q   <= 1'b0; // RULE6
								state_q <= C_IDLE;
							end
							C_RECOV: begin
								bit_q <= bit_q + 4'h1;
								if (bit_q == 4'h8) begin
									bit_q   <= 4'h0;
									state_q <= C_START; // RULE9
								end
							end
							default: begin
								bit_q <= bit_q + 4'h1;
								if (bit_q != 4'h8) begin
									sh_q <= {sh_q[6:0], sda_s_q};
								end else begin
									rsp_valid <= 1'b1;
									rsp_data  <= sh_q;
									rsp_nack  <= sda_s_q;
									state_q   <= C_IDLE;
								end
							end
						endcase
					end
				endcase
			end
		end
	end
endmodule : twi_ctrl

/* File: design/eeprom_dev.sv */
// Purpose: serial memory device end of the two-wire link
// Assumes: link_clk far faster than the serial clock
// Notes:   bus lines are oversampled; writes commit after the timed cycle
// Function
// RULE1 - sample on clock rise, drive after fall
// RULE2 - data output open-drain only
// RULE3 - 256 bytes, 32 pages of 8
// RULE4 - data changes only while clock low
// RULE5 - start begins decoding new transaction
// RULE6 - stop after read returns standby
// RULE7 - acknowledge each 8-bit word on ninth clock
// RULE8 - standby at power-up and after stop
// RULE9 - recover by clocking then start
// RULE10 - device word top nibble must match type
// RULE11 - eighth bit selects read or write
// RULE12 - ack on match, else standby
// RULE13 - byte write: word address then one byte
// RULE14 - timed programming cycle ignores bus
// RULE15 - page write up to eight acknowledged bytes
// RULE16 - write increments low three address bits
// RULE17 - polling acknowledged only after programming
// RULE18 - current, random and sequential reads
// RULE19 - pointer holds last address plus one
// RULE20 - read pointer wraps whole memory
// RULE21 - read shifts out byte at pointer
// RULE22 - controller ack advances to next byte
// RULE23 - synchronise and filter lines before decode
`timescale 1ns/1ps
`include "eeprom_map.svh"
module eeprom_dev #(
	parameter int PROG_CYCLES = `PROG_CYCLES,
	parameter int FILT_CYCLES = `FILT_CYCLES
) (
	// clock and reset
	input  wire logic link_clk,
	input  wire logic sys_rst,
	// status
	output logic      standby,
	output logic      prog_busy,
	// link
	twi_if.dev        bus
);
	import eeprom_pkg::*;

	localparam int PW = $clog2(PROG_CYCLES + 1);
	localparam int PB = `PAGE_BYTES;

	logic            rst_m_q;
	logic            rst_q;
	logic            scl_f;
	logic            sda_f;
	logic            scl_p_q;
	logic            sda_p_q;
	logic            ev_start;
	logic            ev_stop;
	logic            ev_rise;
	logic            ev_fall;
	logic            prog_done;
	logic            byte_end;
	logic            ack_end;
	dev_state_e      state_q;
	logic [3:0]      cnt_q;
	logic [7:0]      sh_q;
	logic [7:0]      ptr_q;
	logic            rw_q;
	logic            mack_q;
	logic            oe_q;
	logic [PW-1:0]   prog_cnt_q;
	logic [4:0]      row_q;
	logic [PB-1:0]   pend_q;
	logic [7:0]      page_q [PB];
	logic [7:0]      mem_q  [`MEM_BYTES];

	function automatic logic addr_match(input logic [7:0] w);
		return w[7:4] == `DEV_TYPE; // RULE10
	endfunction : addr_match

	// ****************************************
	// reset and line conditioning
	// ****************************************
	always_ff @(posedge link_clk) begin
		rst_m_q <= sys_rst;
		rst_q   <= rst_m_q;
	end

	sync_filter #(.CYCLES(FILT_CYCLES)) u_scl_filt ( // RULE23
		.clk   (link_clk),
		.rst   (rst_q),
		.raw   (bus.scl),
		.level (scl_f)
	);

	sync_filter #(.CYCLES(FILT_CYCLES)) u_sda_filt ( // RULE23
		.clk   (link_clk),
		.rst   (rst_q),
		.raw   (bus.sda),
		.level (sda_f)
	);

	always_ff @(posedge link_clk) begin
		if (rst_q) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	// ****************************************
	// bus events
	// ****************************************
	// a data edge while the clock stays high is framing, not data
	assign ev_start  = scl_p_q & scl_f & sda_p_q & ~sda_f; // RULE4 RULE5
	assign ev_stop   = scl_p_q & scl_f & ~sda_p_q & sda_f; // RULE4 RULE6
	assign ev_rise   = ~scl_p_q & scl_f; // RULE1
	assign ev_fall   = scl_p_q & ~scl_f; // RULE1
	assign byte_end  = ev_fall && cnt_q == 4'h8;
	assign ack_end   = ev_fall && cnt_q == 4'h9;
	assign prog_done = (state_q == D_PROG) && (prog_cnt_q == PW'(PROG_CYCLES - 1));

	assign bus.dev_sda_o  = 1'b0; // RULE2
	assign bus.dev_sda_oe = oe_q; // RULE2
	assign standby        = (state_q == D_STANDBY);
	assign prog_busy      = (state_q == D_PROG);

	// ****************************************
	// transaction sequencer
	// ****************************************
	always_ff @(posedge link_clk) begin
		if (rst_q) begin
			state_q    <= D_STANDBY; // RULE8
			cnt_q      <= 4'h0;
			sh_q       <= 8'h00;
			rw_q       <= 1'b0;
			mack_q     <= 1'b0;
			oe_q       <= 1'b0;
			prog_cnt_q <= '0;
		end else if (state_q == D_PROG) begin
			// the line stays released and every edge is ignored until done
			oe_q <= 1'b0; // RULE14 RULE17
			if (prog_done) begin
				state_q <= D_STANDBY; // RULE8
			end else begin
				prog_cnt_q <= prog_cnt_q + PW'(1); // RULE14
			end
		end else if (ev_start) begin
			state_q <= D_DEVADDR; // RULE5 RULE9 RULE10
			cnt_q   <= 4'h0;
			oe_q    <= 1'b0;
		end else if (ev_stop) begin
			oe_q       <= 1'b0;
			prog_cnt_q <= '0;
			if (state_q == D_WDATA && |pend_q) begin
				state_q <= D_PROG; // RULE14
			end else begin
				state_q <= D_STANDBY; // RULE6 RULE8
			end
		end else if (state_q != D_STANDBY) begin
			if (ev_rise && cnt_q != 4'h9) begin
				cnt_q <= cnt_q + 4'h1;
				if (state_q == D_RDATA) begin
					if (cnt_q == 4'h8) begin
						mack_q <= ~sda_f; // RULE22
					end
				end else if (cnt_q != 4'h8) begin
					sh_q <= {sh_q[6:0], sda_f}; // RULE1 RULE7
				end
			end else if (byte_end) begin
				if (state_q == D_RDATA) begin
					oe_q <= 1'b0;
				end else if (state_q == D_DEVADDR && !addr_match(sh_q)) begin
					state_q <= D_STANDBY; // RULE12
					oe_q    <= 1'b0;
				end else begin
					oe_q <= 1'b1; // RULE7 RULE12 RULE13 RULE15
					if (state_q == D_DEVADDR) begin
						rw_q <= sh_q[0]; // RULE11
					end
				end
			end else if (ack_end) begin
				cnt_q <= 4'h0;
				oe_q  <= 1'b0;
				case (state_q)
					D_DEVADDR: begin
						if (rw_q) begin
							state_q <= D_RDATA; // RULE18 RULE21
							sh_q    <= mem_q[ptr_q];
							oe_q    <= ~mem_q[ptr_q][7];
						end else begin
							state_q <= D_WORDADDR; // RULE13
						end
					end
					D_WORDADDR: state_q <= D_WDATA; // RULE13
					D_WDATA:    state_q <= D_WDATA; // RULE15
					D_RDATA: begin
						if (mack_q) begin
							sh_q <= mem_q[ptr_q]; // RULE22
							oe_q <= ~mem_q[ptr_q][7];
						end else begin
							state_q <= D_STANDBY; // RULE21
						end
					end
					default: state_q <= D_STANDBY;
				endcase
			end else if (ev_fall && state_q == D_RDATA && cnt_q != 4'h0) begin
				oe_q <= ~sh_q[6]; // RULE1
				sh_q <= {sh_q[6:0], 1'b0};
			end
		end
	end

	// ****************************************
	// address pointer
	// ****************************************
	// kept across transactions; only reset clears it
	always_ff @(posedge link_clk) begin
		if (rst_q) begin
			ptr_q <= 8'h00;
		end else if (state_q != D_PROG && !ev_start && !ev_stop) begin
			if (byte_end && state_q == D_WORDADDR) begin
				ptr_q <= sh_q; // RULE3 RULE18
			end else if (byte_end && state_q == D_WDATA) begin
				ptr_q <= {ptr_q[7:3], ptr_q[2:0] + 3'h1}; // RULE16 RULE19
			end else if (ack_end && ((state_q == D_DEVADDR && rw_q) ||
			                         (state_q == D_RDATA && mack_q))) begin
				ptr_q <= ptr_q + 8'h01; // RULE19 RULE20
			end
		end
	end

	// ****************************************
	// page buffer and commit
	// ****************************************
	// bytes wait here so an aborted write never touches the array
	always_ff @(posedge link_clk) begin
		if (rst_q || prog_done) begin
			pend_q <= '0;
			row_q  <= 5'h00;
		end else if (state_q != D_PROG && !ev_start && !ev_stop && byte_end) begin
			if (state_q == D_WORDADDR) begin
				row_q  <= sh_q[7:3];
				pend_q <= '0;
			end else if (state_q == D_WDATA) begin
				page_q[ptr_q[2:0]] <= sh_q; // RULE16
				pend_q[ptr_q[2:0]] <= 1'b1; // RULE15
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (prog_done) begin
			for (int i = 0; i < PB; i++) begin
				if (pend_q[i]) begin
					mem_q[{row_q, 3'(i)}] <= page_q[i]; // RULE3 RULE14
				end
			end
		end
	end
endmodule : eeprom_dev

/* File: sim/eeprom_link_asserts.sv */
// Purpose: assertions on the two-wire link between controller and memory
// Assumes: sampled on the device clock; sda is the resolved line
// Notes:   windows allow for the device input filter lag
`timescale 1ns/1ps
module eeprom_link_asserts #(
	parameter int PROG_CYCLES = 200
) (
	// clock and reset
	input wire logic link_clk,
	input wire logic sys_rst,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	// device status
	input wire logic standby,
	input wire logic prog_busy
);
	localparam int BUSY_LO = PROG_CYCLES - 4;
	localparam int BUSY_HI = PROG_CYCLES + 4;
	logic [19:0] busy_cnt_q;

	default clocking cb @(posedge link_clk); endclocking
	default disable iff (sys_rst);

	// the timed cycle is too long for a delay range, so count it
	always_ff @(posedge link_clk) begin
		if (sys_rst || !prog_busy) begin
			busy_cnt_q <= 20'h0;
		end else begin
			busy_cnt_q <= busy_cnt_q + 20'h1;
		end
	end

	// ********************
	// properties
	// ********************
	property p_open_drain;
		dev_sda_oe |-> !dev_sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("device drives sda high");

	property p_chg_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_chg_low: assert property (p_chg_low) else $error("device sda moved with scl high");

	property p_ack_hold;
		$rose(scl) && dev_sda_oe |-> dev_sda_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("device bit dropped in scl high");

	property p_busy_quiet;
		prog_busy |-> !dev_sda_oe;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("device answered while busy");

	property p_busy_at_stop;
		$rose(prog_busy) |-> scl && sda;
	endproperty
	a_busy_at_stop: assert property (p_busy_at_stop) else $error("busy without stop");

	property p_busy_len;
		$fell(prog_busy) |-> busy_cnt_q >= BUSY_LO && busy_cnt_q <= BUSY_HI;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("programming length wrong");

	property p_busy_end;
		$fell(prog_busy) |-> standby;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("no standby after programming");

	property p_standby_quiet;
		standby |-> !dev_sda_oe;
	endproperty
	a_standby_quiet: assert property (p_standby_quiet) else $error("device drives in standby");

	property p_start_wake;
		scl && $fell(sda) && standby |-> ##[1:30] !standby;
	endproperty
	a_start_wake: assert property (p_start_wake) else $error("start not decoded");

	property p_stop_rest;
		scl && $rose(sda) && !prog_busy |-> ##[1:30] (standby || prog_busy);
	endproperty
	a_stop_rest: assert property (p_stop_rest) else $error("stop left device active");

	c_prog: cover property ($rose(prog_busy));
	c_ack: cover property ($rose(dev_sda_oe) && !standby);
	c_start: cover property (scl && $fell(sda) && standby);
endmodule : eeprom_link_asserts

/* File: sim/i2c_serial_eeprom_slave_tb.sv */
// Purpose: controller and memory device joined, driven from the command port
// Assumes: short quarter period and timed cycle to keep the run brief
// Notes:   expectations are queued by the driver and checked on rsp_valid
`timescale 1ns/1ps
module i2c_serial_eeprom_slave_tb;
	import eeprom_pkg::*;
	localparam int Q    = 8;
	localparam int PROG = 4000;
	logic       clock;
	logic       link_clk;
	logic       sys_rst;
	logic       cmd_valid;
	logic       cmd_ready;
	op_e        cmd_op;
	logic [7:0] cmd_data;
	logic       cmd_ack;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_nack;
	logic       standby;
	logic       prog_busy;
	logic [7:0] mem [256];
	logic [9:0] notes [$];
	logic [9:0] note;
	logic [7:0] a;
	logic [7:0] d;
	logic [4:0] pg;
	int         i;
	int         error_cnt;
	int         checked;

	twi_if bus_if ();
	twi_ctrl #(.QUARTER(Q)) u_twi_ctrl (.clock(clock), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack), .bus(bus_if.ctrl));
	eeprom_dev #(.PROG_CYCLES(PROG), .FILT_CYCLES(8)) u_eeprom_dev (.link_clk(link_clk),
		.sys_rst(sys_rst), .standby(standby), .prog_busy(prog_busy), .bus(bus_if.dev));
	eeprom_link_asserts #(.PROG_CYCLES(PROG)) u_eeprom_link_asserts (.link_clk(link_clk),
		.sys_rst(sys_rst), .scl(bus_if.scl), .sda(bus_if.sda), .dev_sda_o(bus_if.dev_sda_o),
		.dev_sda_oe(bus_if.dev_sda_oe), .standby(standby), .prog_busy(prog_busy));

	always #12.5 clock = ~clock;
	// half period of 3 ns keeps every link edge off the x.5 ns edges of clock
	initial link_clk = 1'b0;
	always #3 link_clk = ~link_clk;

	// ********************
	// tasks
	// ********************
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	// held from a falling edge to the next one, across the rising edge that takes it
	task automatic cmd(input op_e o, input logic [7:0] dv, input logic ak);
		int n;
		n = 0;
		@(negedge clock);
		while (cmd_ready !== 1'b1 && n < 4000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 4000) error_cnt++;
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_data = dv;
		cmd_ack = ak;
		@(negedge clock);
		cmd_valid = 1'b0;
	endtask : cmd

	task automatic op(input op_e o);
		cmd(o, 8'h00, 1'b0);
	endtask : op

	task automatic wr(input logic [7:0] dv, input logic nk);
		notes.push_back({1'b0, nk, dv});
		cmd(OP_WRITE, dv, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] dv, input logic ak);
		notes.push_back({1'b1, ~ak, dv});
		cmd(OP_READ, 8'h00, ak);
	endtask : rd

	task automatic commit();
		int n;
		n = 0;
		while (prog_busy !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		check({9'h0, prog_busy}, 10'h1);
		n = 0;
		while (prog_busy !== 1'b0 && n < 2000) begin
			@(negedge clock);
			n++;
		end
		check({9'h0, standby}, 10'h1);
	endtask : commit

	// ********************
	// answer monitor
	// ********************
	always @(negedge clock) begin
		if (rsp_valid === 1'b1) begin
			if (notes.size() == 0) begin
				check({2'h0, rsp_data}, 10'h3ff);
			end else begin
				note = notes.pop_front();
				if (note[9]) begin
					check({1'b1, rsp_nack, rsp_data}, note);
				end else begin
					check({1'b0, rsp_nack, rsp_data}, note);
				end
			end
		end
	end

	initial begin
		#2_000_000;
		error_cnt++;
		finish_test();
	end

	// ********************
	// scenarios
	// ********************
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = OP_START;
		cmd_data = 8'h00;
		cmd_ack = 1'b0;
		error_cnt = 0;
		checked = 0;
		void'($urandom(32'habcb46e0));
		repeat (4) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		repeat (2) @(negedge clock);
		check({8'h0, standby, prog_busy}, 10'h2);
		op(OP_RECOVER);
		wr(8'ha0, 1'b0);
		op(OP_STOP);
		op(OP_START);
		wr({4'h5, 3'($urandom), 1'b0}, 1'b1);
		op(OP_STOP);
		// ten bytes into a page of eight: the first two are overwritten
		pg = 5'($urandom);
		op(OP_START);
		wr(8'ha0, 1'b0);
		wr({pg, 3'h5}, 1'b0);
		for (i = 0; i < 10; i++) begin
			d = 8'($urandom);
			mem[{pg, 3'(5 + i)}] = d;
			wr(d, 1'b0);
		end
		op(OP_STOP);
		op(OP_START);
		wr(8'ha0, 1'b1);
		op(OP_STOP);
		commit();
		op(OP_START);
		wr(8'ha0, 1'b0);
		wr({pg, 3'h0}, 1'b0);
		op(OP_START);
		wr(8'ha1, 1'b0);
		for (i = 0; i < 8; i++) begin
			rd(mem[{pg, 3'(i)}], i < 7);
		end
		op(OP_STOP);
		for (i = 0; i < 3; i++) begin
			a = 8'(255 + i);
			d = 8'($urandom);
			mem[a] = d;
			op(OP_START);
			wr(8'ha0, 1'b0);
			wr(a, 1'b0);
			wr(d, 1'b0);
			op(OP_STOP);
			commit();
		end
		op(OP_START);
		wr(8'ha0, 1'b0);
		wr(8'hff, 1'b0);
		op(OP_START);
		wr(8'ha1, 1'b0);
		rd(mem[8'hff], 1'b1);
		rd(mem[8'h00], 1'b0);
		op(OP_STOP);
		op(OP_START);
		wr(8'ha1, 1'b0);
		rd(mem[8'h01], 1'b0);
		op(OP_STOP);
		i = 0;
		while ((notes.size() != 0 || cmd_ready !== 1'b1) && i < 4000) begin
			@(negedge clock);
			i++;
		end
		if (notes.size() != 0) error_cnt++;
		finish_test();
	end
endmodule : i2c_serial_eeprom_slave_tb
